// [design/ucd_baud_div.sv]
// Purpose: one-cycle baud enable pulse from the bus clock
// Assumes: fixed divisor from the register header
// Notes: pulse comes straight from a flip-flop
`timescale 1ns/1ns
`include "ucd_regs.svh"
module ucd_baud_div (
    input wire logic clk_i, // bus clock
    input wire logic rst_i, // synchronous reset, high
    output logic baud_en_o // one pulse per bit time
);
    ucd_pkg::ucd_div_state_s q, d;

    always_comb
    begin
        d = q;
        d.en = 1'b0;
        if (q.cnt == 11'(`UCD_BAUD_DIV - 1))
        begin
            d.cnt = 11'h000;
            d.en = 1'b1;
        end
        else
        begin
            d.cnt = q.cnt + 11'h001;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign baud_en_o = q.en;
endmodule : ucd_baud_div

// [design/ucd_pkg.sv]
// Purpose: shared types and helpers of the uart control/data block
// Assumes: constants come from ucd_regs.svh
// Notes: nothing here is imported, users write ucd_pkg::name
package ucd_pkg;

    typedef enum logic {TX_IDLE, TX_SHIFT} ucd_tx_state_e;

    typedef struct packed {
        logic load;
        logic [7:0] data;
        logic noise;
        logic framing;
        logic parity;
    } ucd_rx_evt_s;

    typedef struct packed {
        logic loop_mode_select;
        logic receiver_source_select;
    } ucd_mode_s;

    typedef struct packed {
        logic [10:0] cnt;
        logic en;
    } ucd_div_state_s;

    typedef struct packed {
        ucd_tx_state_e st;
        logic [9:0] shreg;
        logic [3:0] cnt;
        logic line;
    } ucd_shift_state_s;

    typedef struct packed {
        logic ack;
        logic [7:0] dat;
        logic [7:0] ctrl3;
        logic [7:0] rxbuf;
        logic [7:0] txbuf;
        logic transmit_buffer_empty_flag;
        logic receive_buffer_full_flag;
        logic [3:0] err;
        logic rx_arm;
        logic tx_arm;
        logic txd;
        logic txd_oe_n;
        logic irq;
    } ucd_top_state_s;

    function automatic logic ucd_hit(input logic [5:0] adr, input logic [3:0] idx);
        return adr[5:2] == idx;
    endfunction : ucd_hit

    // clear first, then set, so a same-cycle event is never lost
    function automatic logic [3:0] ucd_set_clr(input logic [3:0] cur, input logic [3:0] set,
                                               input logic [3:0] clr);
        return (cur & ~clr) | set;
    endfunction : ucd_set_clr

endpackage : ucd_pkg

// [design/ucd_regs.svh]
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: word-aligned registers, index times four is the byte address
// Notes: definitions only
`ifndef UCD_REGS_SVH
`define UCD_REGS_SVH

// ======================================================================
// register indices
`define UCD_IDX_STATUS 4'h4
`define UCD_IDX_CTRL3 4'h6
`define UCD_IDX_DATA 4'h7

// ======================================================================
// control three fields
`define UCD_C3_PARITY_IE 0
`define UCD_C3_FRAMING_IE 1
`define UCD_C3_NOISE_IE 2
`define UCD_C3_OVERRUN_IE 3
`define UCD_C3_TX_INVERT 4
`define UCD_C3_PIN_DIR 5
`define UCD_C3_WR_MASK 8'h3f
`define UCD_C3_RESET 8'h00

// ======================================================================
// status fields, error flags share the enable layout
`define UCD_ST_PARITY 0
`define UCD_ST_FRAMING 1
`define UCD_ST_NOISE 2
`define UCD_ST_OVERRUN 3
`define UCD_ST_RX_FULL 5
`define UCD_ST_TX_EMPTY 7
`define UCD_ERR_RESET 4'h0

// ======================================================================
// timing
`define UCD_CLK_HZ 10000000
`define UCD_BAUD_HZ 9600
`define UCD_BAUD_DIV (`UCD_CLK_HZ / `UCD_BAUD_HZ)
`define UCD_FRAME_BITS 4'ha

`endif

// [design/ucd_top.sv]
// Purpose: uart control three and data registers with wishbone access
// Assumes: receiver logic outside delivers characters and error events
// Notes: error flags are sticky, the control three enables are their mask
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ns
`include "ucd_regs.svh"
module ucd_top (
    input wire logic clk_i, // bus clock, 10 MHz
    input wire logic rst_i, // synchronous reset, high
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [5:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // wishbone acknowledge
    input wire ucd_pkg::ucd_rx_evt_s rx_evt_i, // received character and errors
    input wire ucd_pkg::ucd_mode_s mode_i, // loop and source selects
    output logic txd_o, // serial transmit level
    output logic txd_oe_n_o, // low while the pin is driven
    output logic irq_o // level interrupt request
);
    ucd_pkg::ucd_top_state_s q, d;

    logic baud_en;
    logic shift_busy;
    logic shift_line;
    logic take;
    logic acc;
    logic rd_status;
    logic rd_data;
    logic wr_data;
    logic wr_status;
    logic wr_ctrl3;
    logic rx_clear;
    logic single_wire;
    logic [3:0] err_set;
    logic [3:0] err_clr;

    // ======================================================================
    // baud enable and transmit shifter
    ucd_baud_div u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .baud_en_o(baud_en)
    );

    ucd_tx_shift u_shift (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .baud_en_i(baud_en),
        .load_i(take),
        .data_i(q.txbuf),
        .busy_o(shift_busy),
        .line_o(shift_line)
    );

    // ======================================================================
    // bus decode, one access taken per request, ack one cycle later
    assign acc = wb_cyc_i && wb_stb_i && !q.ack;
    assign rd_status = acc && !wb_we_i && ucd_pkg::ucd_hit(wb_adr_i, `UCD_IDX_STATUS);
    assign rd_data = acc && !wb_we_i && ucd_pkg::ucd_hit(wb_adr_i, `UCD_IDX_DATA);
    assign wr_status = acc && wb_we_i && wb_sel_i[0] &&
                       ucd_pkg::ucd_hit(wb_adr_i, `UCD_IDX_STATUS);
    assign wr_data = acc && wb_we_i && wb_sel_i[0] && ucd_pkg::ucd_hit(wb_adr_i, `UCD_IDX_DATA);
    assign wr_ctrl3 = acc && wb_we_i && wb_sel_i[0] && ucd_pkg::ucd_hit(wb_adr_i, `UCD_IDX_CTRL3);

    // second step of the receive clearing sequence
    assign rx_clear = rd_data && q.rx_arm;
    // the shifter only moves on a baud pulse so frames start on bit edges
    assign take = baud_en && !shift_busy && !q.transmit_buffer_empty_flag;
    assign single_wire = mode_i.loop_mode_select && mode_i.receiver_source_select;

    assign err_set = rx_evt_i.load ?
                     {q.receive_buffer_full_flag && !rx_clear, rx_evt_i.noise, rx_evt_i.framing, rx_evt_i.parity} :
                     4'h0;
    assign err_clr = (wr_status ? wb_dat_i[3:0] : 4'h0) | (rx_clear ? 4'hf : 4'h0);

    // ======================================================================
    // next state
    always_comb
    begin
        d = q;
        d.ack = acc;
        if (acc)
        begin
            d.dat = 8'h00;
            if (!wb_we_i)
            begin
                if (ucd_pkg::ucd_hit(wb_adr_i, `UCD_IDX_DATA))
                begin
                    d.dat = q.rxbuf;
                end
                else if (ucd_pkg::ucd_hit(wb_adr_i, `UCD_IDX_CTRL3))
                begin
                    d.dat = q.ctrl3;
                end
                else if (ucd_pkg::ucd_hit(wb_adr_i, `UCD_IDX_STATUS))
                begin
                    d.dat[`UCD_ST_TX_EMPTY] = q.transmit_buffer_empty_flag;
                    d.dat[`UCD_ST_RX_FULL] = q.receive_buffer_full_flag;
                    d.dat[3:0] = q.err;
                end
            end
        end

        if (wr_ctrl3)
        begin
            d.ctrl3 = wb_dat_i[7:0] & `UCD_C3_WR_MASK;
        end

        // status read arms the clearing sequences
        if (rd_status && q.receive_buffer_full_flag)
        begin
            d.rx_arm = 1'b1;
        end
        if (rd_status && q.transmit_buffer_empty_flag)
        begin
            d.tx_arm = 1'b1;
        end

        // transmit buffer, receive contents untouched
        if (wr_data)
        begin
            d.txbuf = wb_dat_i[7:0];
            if (q.tx_arm && q.transmit_buffer_empty_flag)
            begin
                d.transmit_buffer_empty_flag = 1'b0;
                d.tx_arm = 1'b0;
            end
        end
        if (take)
        begin
            d.transmit_buffer_empty_flag = 1'b1;
        end

        // receive side, a new character beats a same-cycle clear
        if (rx_clear)
        begin
            d.receive_buffer_full_flag = 1'b0;
            d.rx_arm = 1'b0;
        end
        if (rx_evt_i.load && (!q.receive_buffer_full_flag || rx_clear))
        begin
            d.rxbuf = rx_evt_i.data;
            d.receive_buffer_full_flag = 1'b1;
        end
        d.err = ucd_pkg::ucd_set_clr(q.err, err_set, err_clr);

        // pin level and direction
        d.txd = shift_line ^ q.ctrl3[`UCD_C3_TX_INVERT];
        d.txd_oe_n = single_wire ? !q.ctrl3[`UCD_C3_PIN_DIR] : 1'b0;

        d.irq = (q.err[`UCD_ST_OVERRUN] && q.ctrl3[`UCD_C3_OVERRUN_IE]) ||
                (q.err[`UCD_ST_NOISE] && q.ctrl3[`UCD_C3_NOISE_IE]) ||
                (q.err[`UCD_ST_FRAMING] && q.ctrl3[`UCD_C3_FRAMING_IE]) ||
                (q.err[`UCD_ST_PARITY] && q.ctrl3[`UCD_C3_PARITY_IE]);
    end

    // ======================================================================
    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.ctrl3 <= `UCD_C3_RESET;
            q.err <= `UCD_ERR_RESET;
            q.transmit_buffer_empty_flag <= 1'b1;
            q.txd <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign wb_dat_o = {24'h000000, q.dat};
    assign wb_ack_o = q.ack;
    assign txd_o = q.txd;
    assign txd_oe_n_o = q.txd_oe_n;
    assign irq_o = q.irq;

    // ======================================================================
    // assertions
    // every output is registered, so each consequent looks one cycle on (idle_invert_a does it through [*2] and |->)
    single_wire_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
        single_wire |=> txd_oe_n_o == !$past(q.ctrl3[`UCD_C3_PIN_DIR]))
        else $error("pin direction wrong in single-wire mode");

    normal_pin_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !single_wire |=> !txd_oe_n_o)
        else $error("pin released outside single-wire mode");

    tx_invert_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> txd_o == ($past(shift_line) ^ $past(q.ctrl3[`UCD_C3_TX_INVERT])))
        else $error("transmit polarity wrong");

    idle_invert_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!shift_busy && q.ctrl3[`UCD_C3_TX_INVERT])[*2] |-> !txd_o)
        else $error("idle level not inverted");

    overrun_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.err[`UCD_ST_OVERRUN] && q.ctrl3[`UCD_C3_OVERRUN_IE] |=> irq_o)
        else $error("overrun request missing");

    noise_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.err[`UCD_ST_NOISE] && q.ctrl3[`UCD_C3_NOISE_IE] |=> irq_o)
        else $error("noise request missing");

    framing_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.err[`UCD_ST_FRAMING] && q.ctrl3[`UCD_C3_FRAMING_IE] |=> irq_o)
        else $error("framing request missing");

    parity_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.err[`UCD_ST_PARITY] && q.ctrl3[`UCD_C3_PARITY_IE] |=> irq_o)
        else $error("parity request missing");

    no_spurious_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.err & q.ctrl3[3:0]) == 4'h0 |=> !irq_o)
        else $error("interrupt without enabled flag");

    data_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_data && !rx_evt_i.load |=>
        q.txbuf == $past(wb_dat_i[7:0]) && q.rxbuf == $past(q.rxbuf))
        else $error("data write disturbed receive buffer");

    data_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_data |=> wb_ack_o && wb_dat_o[7:0] == $past(q.rxbuf) ##1 !wb_ack_o)
        else $error("data read returned wrong value");

    rx_clear_seq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_data && q.rx_arm && !rx_evt_i.load |=> !q.receive_buffer_full_flag && !q.rx_arm)
        else $error("receive full not cleared by sequence");

    tx_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
        take |=> q.transmit_buffer_empty_flag && shift_busy)
        else $error("shifter did not take waiting data");

    tx_clear_seq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_data && q.tx_arm && q.transmit_buffer_empty_flag |=> !q.transmit_buffer_empty_flag)
        else $error("transmit empty not cleared by sequence");

    ctrl3_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ctrl3 |=> q.ctrl3 == ($past(wb_dat_i[7:0]) & `UCD_C3_WR_MASK))
        else $error("control three write not masked");

    data_read_tx_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_data |=> q.txbuf == $past(q.txbuf))
        else $error("data read disturbed transmit buffer");

    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");

    rx_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_evt_i.load && !q.receive_buffer_full_flag |=> q.receive_buffer_full_flag && q.rxbuf == $past(rx_evt_i.data))
        else $error("received character not buffered");

    overrun_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_evt_i.load && q.receive_buffer_full_flag && !rx_clear |=>
        q.err[`UCD_ST_OVERRUN] && q.rxbuf == $past(q.rxbuf))
        else $error("overrun not flagged or buffer overwritten");

    tx_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !q.transmit_buffer_empty_flag && shift_busy |=> !q.transmit_buffer_empty_flag)
        else $error("waiting character lost while shifter busy");

    unarmed_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_data && !q.tx_arm && !take |=> q.transmit_buffer_empty_flag == $past(q.transmit_buffer_empty_flag))
        else $error("unarmed data write changed transmit empty");

    rx_clear_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_clear && !rx_evt_i.load |=> q.err == 4'h0)
        else $error("error flags kept after clearing sequence");

    err_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !rx_evt_i.load && !rx_clear && !wr_status |=> q.err == $past(q.err))
        else $error("error flag changed without cause");

    w1c_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_status && !rx_evt_i.load |=> (q.err & $past(wb_dat_i[3:0])) == 4'h0)
        else $error("written one did not clear error flag");

    overrun_cov: cover property (@(posedge clk_i) disable iff (rst_i)
        rx_evt_i.load && q.receive_buffer_full_flag && !rx_clear ##1 q.err[`UCD_ST_OVERRUN]);
    irq_cov: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
    take_cov: cover property (@(posedge clk_i) disable iff (rst_i) take);
    single_wire_in_cov: cover property (@(posedge clk_i) disable iff (rst_i) txd_oe_n_o);
    rx_clear_cov: cover property (@(posedge clk_i) disable iff (rst_i) rx_clear);
endmodule : ucd_top

// [design/ucd_tx_shift.sv]
// Purpose: transmit shifter, start bit, eight data bits lsb first, stop bit
// Assumes: load_i only pulses together with baud_en_i while busy_o is low
// Notes: line_o idles high, polarity is applied by the caller
`timescale 1ns/1ns
`include "ucd_regs.svh"
module ucd_tx_shift (
    input wire logic clk_i, // bus clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic baud_en_i, // bit time pulse
    input wire logic load_i, // take data_i into the shifter
    input wire logic [7:0] data_i, // character to send
    output logic busy_o, // frame in progress
    output logic line_o // uninverted serial level
);
    ucd_pkg::ucd_shift_state_s q, d;

    always_comb
    begin
        d = q;
        unique case (q.st)
            ucd_pkg::TX_IDLE:
            begin
                d.line = 1'b1;
                if (load_i)
                begin
                    d.shreg = {1'b1, data_i, 1'b0};
                    d.cnt = `UCD_FRAME_BITS;
                    d.st = ucd_pkg::TX_SHIFT;
                end
            end
            ucd_pkg::TX_SHIFT:
            begin
                if (baud_en_i)
                begin
                    if (q.cnt == 4'h0)
                    begin
                        // the stop bit has now stood a full bit time
                        d.st = ucd_pkg::TX_IDLE;
                    end
                    else
                    begin
                        d.line = q.shreg[0];
                        d.shreg = {1'b1, q.shreg[9:1]};
                        d.cnt = q.cnt - 4'h1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '{st: ucd_pkg::TX_IDLE, shreg: 10'h3ff, cnt: 4'h0, line: 1'b1};
        end
        else
        begin
            q <= d;
        end
    end

    assign busy_o = (q.st == ucd_pkg::TX_SHIFT);
    assign line_o = q.line;
endmodule : ucd_tx_shift

// [sim/ucd_serial_peer.sv]
// Purpose: remote serial receiver that decodes frames seen on the transmit line
// Assumes: start bit, 8 data bits lsb first, one stop bit, BIT_CLKS clocks per bit
// Notes: polarity is told by the bench; only listens, never drives the pin
`timescale 1ns/1ns
module ucd_serial_peer #(
    parameter int BIT_CLKS = 1041
) (
    input wire logic clk_i, // bus clock
    input wire logic line_i, // transmit line as driven
    input wire logic inv_i, // polarity inversion in force
    output logic [7:0] byte_o, // last byte received
    output logic [7:0] frames_o, // frames received
    output logic [7:0] bad_o // frames with a bad stop bit
);
    // ======================================================================
    // decoder
    initial
    begin
        byte_o = 8'h00;
        frames_o = 8'h00;
        bad_o = 8'h00;
        forever
        begin
            @(posedge clk_i);
            if ((line_i ^ inv_i) == 1'b0)
            begin
                repeat (BIT_CLKS / 2) @(posedge clk_i);
                // recheck at mid bit: a polarity change looks like a start edge
                if ((line_i ^ inv_i) == 1'b0)
                begin
                    for (int i = 0; i < 8; i++)
                    begin
                        repeat (BIT_CLKS) @(posedge clk_i);
                        byte_o[i] = line_i ^ inv_i;
                    end
                    repeat (BIT_CLKS) @(posedge clk_i);
                    if ((line_i ^ inv_i) !== 1'b1)
                        bad_o = bad_o + 8'h01;
                    frames_o = frames_o + 8'h01;
                end
            end
        end
    end
endmodule : ucd_serial_peer

// [sim/ucd_top_tb.sv]
// Purpose: self-checking bench of the control three and data registers
// Assumes: wishbone answers within a few cycles; status at 0x10
// Notes: two real frames are sent, so the run lasts about 25k cycles
`timescale 1ns/1ns
`include "ucd_regs.svh"
module ucd_top_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [5:0] wb_adr_i = 6'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    ucd_pkg::ucd_rx_evt_s rx_evt_i = '0;
    ucd_pkg::ucd_mode_s mode_i = '0;
    logic txd_o, txd_oe_n_o, irq_o;
    logic peer_inv = 1'b0;
    logic [7:0] peer_byte, peer_frames, peer_bad;
    int err_total = 0;
    int checks_done = 0;
    int seed = 32'h0dd1;
    int r, n;
    logic [7:0] rd, v, d, tx_byte;
    logic [3:0] en, m, err;
    logic [2:0] e3;

    always #50 clk_i = ~clk_i;

    ucd_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_evt_i(rx_evt_i), .mode_i(mode_i),
        .txd_o(txd_o), .txd_oe_n_o(txd_oe_n_o), .irq_o(irq_o));

    ucd_serial_peer #(.BIT_CLKS(`UCD_BAUD_DIV)) u_peer (.clk_i(clk_i), .line_i(txd_o),
        .inv_i(peer_inv), .byte_o(peer_byte), .frames_o(peer_frames), .bad_o(peer_bad));

    // ======================================================================
    // helpers
    function automatic logic [7:0] exp_st(input logic receive_buffer_full_flag, input logic [3:0] e);
        return {1'b1, 1'b0, receive_buffer_full_flag, 1'b0, e};
    endfunction : exp_st

    function automatic logic exp_oe(input logic [1:0] md, input logic dir);
        return (md == 2'b11) ? ~dir : 1'b0;
    endfunction : exp_oe

    task automatic final_report;
        if (err_total == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wb_xfer(input logic we, input logic [5:0] adr, input logic [7:0] wd,
                           input logic [3:0] sel, output logic [7:0] rdat);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h0, wd};
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 20);
        if (k >= 20)
        begin
            err_total++;
            final_report();
        end
        rdat = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_xfer

    task automatic rx_push(input logic [7:0] dv, input logic [2:0] ev);
        @(posedge clk_i);
        rx_evt_i <= {1'b1, dv, ev};
        @(posedge clk_i);
        rx_evt_i <= '0;
    endtask : rx_push

    task automatic settle;
        repeat (3) @(posedge clk_i);
    endtask : settle

    // ======================================================================
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("txd reset", txd_o, 1'b1);
        check("irq reset", irq_o, 1'b0);
        wb_xfer(1'b0, 6'h18, 8'h00, 4'hf, rd);
        check("ctrl3 reset", rd, 8'h00);
        wb_xfer(1'b1, 6'h1c, 8'h5a, 4'hf, rd); // unarmed write, must not be sent
        wb_xfer(1'b0, 6'h10, 8'h00, 4'hf, rd);
        check("status unarmed", rd, exp_st(1'b0, 4'h0));
        wb_xfer(1'b1, 6'h3c, 8'hff, 4'hf, rd);
        wb_xfer(1'b0, 6'h3c, 8'h00, 4'hf, rd);
        check("unmapped", rd, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            r = $random(seed);
            v = {r[7:6], i[2], r[4:0]};
            mode_i <= i[1:0];
            wb_xfer(1'b1, 6'h18, v, 4'hf, rd);
            wb_xfer(1'b1, 6'h18, ~v, 4'he, rd);
            wb_xfer(1'b0, 6'h18, 8'h00, 4'hf, rd);
            check("ctrl3", rd, v & 8'h3f);
            settle();
            check("pin dir", txd_oe_n_o, exp_oe(i[1:0], i[2]));
            check("txd idle", txd_o, !v[4]);
            check("irq quiet", irq_o, 1'b0);
        end
        mode_i <= '0;
        for (int i = 0; i < 6; i++)
        begin
            r = $random(seed);
            en = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : r[3:0];
            d = r[15:8];
            e3 = r[18:16];
            m = r[23:20];
            wb_xfer(1'b1, 6'h18, {4'h0, en}, 4'hf, rd);
            rx_push(d, e3);
            settle();
            err = {1'b0, e3};
            check("irq char", irq_o, |(err & en));
            rx_push(~d, 3'b000);
            settle();
            err = {1'b1, e3};
            check("irq overrun", irq_o, |(err & en));
            wb_xfer(1'b1, 6'h10, {4'h0, m}, 4'hf, rd);
            err = err & ~m;
            settle();
            check("irq cleared", irq_o, |(err & en));
            wb_xfer(1'b0, 6'h10, 8'h00, 4'hf, rd);
            check("status err", rd, exp_st(1'b1, err));
            wb_xfer(1'b0, 6'h1c, 8'h00, 4'hf, rd);
            check("rx data", rd, d);
            wb_xfer(1'b0, 6'h10, 8'h00, 4'hf, rd);
            check("status after", rd, exp_st(1'b0, 4'h0));
            settle();
            check("irq idle", irq_o, 1'b0);
        end
        for (int k = 0; k < 2; k++)
        begin
            r = $random(seed);
            d = r[7:0];
            tx_byte = r[15:8];
            wb_xfer(1'b1, 6'h18, {3'b000, k[0], 4'h0}, 4'hf, rd);
            peer_inv <= k[0];
            repeat (600) @(posedge clk_i);
            check("txd idle inv", txd_o, !k[0]);
            rx_push(d, 3'b000);
            wb_xfer(1'b0, 6'h10, 8'h00, 4'hf, rd);
            check("status full", rd, exp_st(1'b1, 4'h0));
            wb_xfer(1'b1, 6'h1c, tx_byte, 4'hf, rd);
            wb_xfer(1'b0, 6'h1c, 8'h00, 4'hf, rd);
            check("rx kept", rd, d);
            wb_xfer(1'b0, 6'h10, 8'h00, 4'hf, rd);
            check("rx cleared", rd & 8'h2f, 8'h00);
            n = 0;
            while (peer_frames == 8'(k) && n < 15000)
            begin
                @(posedge clk_i);
                n++;
            end
            check("frame seen", n < 15000, 1'b1);
            if (n >= 15000)
            begin
                final_report();
            end
            check("tx byte", peer_byte, tx_byte);
            check("stop bit", peer_bad, 8'h00);
            wb_xfer(1'b0, 6'h10, 8'h00, 4'hf, rd);
            check("tx empty", rd, exp_st(1'b0, 4'h0));
        end
        check("frame count", peer_frames, 8'h02);
        final_report();
    end
endmodule : ucd_top_tb
